// [pkg/fps_defs.vh]
// Constants of the flyback protection sequencer.
// Assumes a 125 MHz system clock; all times are converted to cycles here.
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH
`define FPS_CLK_MHZ 125
// Overload time-out, 27.5 ms
`define FPS_OVL_US 27500
`define FPS_OVL_CYC (`FPS_OVL_US * `FPS_CLK_MHZ)
// Switching periods in ns: 65 kHz, 25 kHz, below 25 kHz, 130 kHz peak
`define FPS_PER_HIGH_NS 15385
`define FPS_PER_MED_NS 40000
`define FPS_PER_LOW_NS 80000
`define FPS_PER_PEAK_NS 7700
`define FPS_PER_CAP_NS 10000
`define FPS_PER_STRETCH_NS 28000
`define FPS_NS2CYC(t) (((t) * `FPS_CLK_MHZ) / 1000)
// Blanking, runaway check and sampling delays in ns
`define FPS_BLANK_NS 300
`define FPS_RUNAWAY_NS 1000
`define FPS_SAMPLE_NS 2000
`define FPS_MAXON_NS 6930
// Counts
`define FPS_OVP_CNT 3'h4
`define FPS_RESTARTS 2'h3
`define FPS_BURST_PULSES 2'h2
// Power modes
`define FPS_MODE_PEAK 2'h0
`define FPS_MODE_HIGH 2'h1
`define FPS_MODE_MED 2'h2
`define FPS_MODE_LOW 2'h3
`define FPS_CW 24
`endif

// [logic/fps_ovp_count.v]
// Consecutive-cycle overvoltage counter used for both OVP sources.
// Assumes cyc_i pulses once per switching cycle with a valid level_i.
`timescale 1ns/100ps
`include "fps_defs.vh"
module fps_ovp_count (
  input wire clk_i,
  input wire sys_rst_i,
  input wire cyc_i,
  input wire level_i,
  output reg trip_o
);
  reg [2:0] count;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= 3'h0;
      trip_o <= 1'b0;
    end else if (cyc_i) begin
      if (!level_i) begin
        count <= 3'h0;
      end else if (count != `FPS_OVP_CNT) begin
        count <= count + 3'h1;
        if (count == `FPS_OVP_CNT - 3'h1) begin
          trip_o <= 1'b1;
        end
      end
    end
  end
endmodule // fps_ovp_count

// [logic/fps_sequencer.v]
// Flyback protection sequencer: gate timing, power modes and protections.
// Assumes all comparator flags are synchronous single-bit inputs.
`timescale 1ns/100ps
`include "fps_defs.vh"
module fps_sequencer (
  input wire clk_i,
  input wire sys_rst_i,
  input wire demand_over_400mv_i,
  input wire demand_above_min_i,
  input wire current_over_target_i,
  input wire sense_over_ovp_i,
  input wire sense_over_half_ovp_i,
  input wire supply_over_ovp_i,
  input wire supply_below_burst_i,
  input wire supply_below_lockout_i,
  input wire supply_at_startup_i,
  input wire high_mains_i,
  input wire junction_hot_i,
  input wire [1:0] power_mode_i,
  output reg gate_o,
  output reg peak_low_clamp_o,
  output reg peak_boost_o,
  output reg opp_comp_en_o,
  output reg overload_shutdown_o,
  output reg latched_off_o,
  output reg runaway_current_guard_o,
  output reg power_down_o
);
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT_LOW = 2'h1;
  localparam ST_WAIT_UP = 2'h2;
  localparam ST_LATCH = 2'h3;
  localparam CW = `FPS_CW;
  localparam [CW-1:0] BLANK = `FPS_NS2CYC(`FPS_BLANK_NS);
  localparam [CW-1:0] RUNAWAY = `FPS_NS2CYC(`FPS_RUNAWAY_NS);
  localparam [CW-1:0] SAMPLE = `FPS_NS2CYC(`FPS_SAMPLE_NS);
  localparam [CW-1:0] MAXON = `FPS_NS2CYC(`FPS_MAXON_NS);
  localparam [CW-1:0] P_PEAK = `FPS_NS2CYC(`FPS_PER_PEAK_NS);
  localparam [CW-1:0] P_CAP = `FPS_NS2CYC(`FPS_PER_CAP_NS);
  localparam [CW-1:0] P_HIGH = `FPS_NS2CYC(`FPS_PER_HIGH_NS);
  localparam [CW-1:0] P_MED = `FPS_NS2CYC(`FPS_PER_MED_NS);
  localparam [CW-1:0] P_LOW = `FPS_NS2CYC(`FPS_PER_LOW_NS);
  localparam [CW-1:0] P_STR = `FPS_NS2CYC(`FPS_PER_STRETCH_NS);
  // Long count is a parameter so simulation can shorten it
  parameter [CW-1:0] OVL_CYC = `FPS_OVL_CYC;

  reg [1:0] state;
  reg [1:0] restarts_left;
  reg [CW-1:0] per_cnt;
  reg [CW-1:0] per_len;
  reg [CW-1:0] off_cnt;
  reg [CW-1:0] ovl_cnt;
  reg sampling;
  reg stretch;
  reg burst_active;
  reg [1:0] burst_left;
  reg cyc_pulse;
  reg vout_low;
  reg [CW-1:0] next_per_len;
  wire sense_trip;
  wire supply_trip;
  wire running;
  wire guard_on;
  wire latch_req;
  wire [CW-1:0] ovl_limit;
  wire stop_now;

  // Comparator flags are used as-is; they arrive synchronous
  assign running = (state == ST_RUN);
  // Runaway guard only during overload with collapsed output
  assign guard_on = demand_over_400mv_i && vout_low;
  assign ovl_limit = guard_on ? (OVL_CYC >> 1) : OVL_CYC;
  assign latch_req = sense_trip | supply_trip | junction_hot_i;
  // Gate drops in the same edge the protection state is left
  assign stop_now = !running || latch_req || supply_below_lockout_i ||
                    (demand_over_400mv_i && ovl_cnt >= ovl_limit);

  // Both OVP sources counted per switching cycle
  fps_ovp_count u_sense_ovp (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cyc_i(cyc_pulse),
    .level_i(sense_over_ovp_i),
    .trip_o(sense_trip)
  );
  fps_ovp_count u_supply_ovp (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cyc_i(cyc_pulse),
    .level_i(supply_over_ovp_i),
    .trip_o(supply_trip)
  );

  // Period selection per power mode
  always @* begin
    case (power_mode_i)
      `FPS_MODE_PEAK: next_per_len = high_mains_i ? P_CAP : P_PEAK;
      `FPS_MODE_HIGH: next_per_len = P_HIGH;
      `FPS_MODE_MED: next_per_len = P_MED;
      `FPS_MODE_LOW: next_per_len = P_LOW;
      default: next_per_len = P_HIGH;
    endcase
    if (stretch) begin
      next_per_len = P_STR;
    end
  end

  // Mode-dependent peak current shaping
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      peak_low_clamp_o <= 1'b0;
      peak_boost_o <= 1'b0;
      opp_comp_en_o <= 1'b0;
    end else begin
      peak_low_clamp_o <= (power_mode_i == `FPS_MODE_LOW);
      peak_boost_o <= (power_mode_i == `FPS_MODE_PEAK);
      opp_comp_en_o <= (power_mode_i == `FPS_MODE_PEAK) ||
                       (power_mode_i == `FPS_MODE_HIGH);
    end
  end

  // Overload timer
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovl_cnt <= {CW{1'b0}};
      runaway_current_guard_o <= 1'b0;
    end else begin
      runaway_current_guard_o <= guard_on && running;
      if (!demand_over_400mv_i || !running) begin
        ovl_cnt <= {CW{1'b0}};
      end else if (ovl_cnt < ovl_limit) begin
        ovl_cnt <= ovl_cnt + 1'b1;
      end
    end
  end

  // Gate timing, sampling and burst recharge
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_o <= 1'b0;
      per_cnt <= {CW{1'b0}};
      per_len <= P_HIGH;
      off_cnt <= {CW{1'b0}};
      sampling <= 1'b0;
      stretch <= 1'b0;
      vout_low <= 1'b0;
      cyc_pulse <= 1'b0;
      burst_active <= 1'b0;
      burst_left <= 2'h0;
    end else begin
      cyc_pulse <= 1'b0;
      if (stop_now) begin
        gate_o <= 1'b0;
        per_cnt <= {CW{1'b0}};
        sampling <= 1'b0;
        burst_active <= 1'b0;
        burst_left <= 2'h0;
      end else begin
        if (per_cnt + 1'b1 < per_len) begin
          per_cnt <= per_cnt + 1'b1;
        end
        // New cycle only with demand, or as a burst recharge pulse
        if (per_cnt + 1'b1 >= per_len && !gate_o) begin
          if (demand_above_min_i || burst_left != 2'h0) begin
            gate_o <= 1'b1;
            per_cnt <= {CW{1'b0}};
            per_len <= next_per_len;
            stretch <= 1'b0;
            if (!demand_above_min_i) begin
              burst_left <= burst_left - 2'h1;
            end
          end
        end
        // Exactly two pulses per supply dip while idle
        if (!demand_above_min_i && supply_below_burst_i && !burst_active) begin
          burst_active <= 1'b1;
          burst_left <= `FPS_BURST_PULSES;
        end
        if (demand_above_min_i || !supply_below_burst_i) begin
          if (burst_left == 2'h0) begin
            burst_active <= 1'b0;
          end
        end
        if (gate_o) begin
          // Over target within 1 us, even if the pulse ends at blanking
          if (per_cnt + 1'b1 >= BLANK && per_cnt + 1'b1 <= RUNAWAY &&
              current_over_target_i && guard_on) begin
            stretch <= 1'b1;
          end
          // Blanking hides the comparator; max on-time bounds the pulse
          if ((per_cnt + 1'b1 >= BLANK && current_over_target_i) ||
              per_cnt + 1'b1 >= MAXON) begin
            gate_o <= 1'b0;
            sampling <= 1'b1;
            off_cnt <= {CW{1'b0}};
          end
        end
        if (sampling) begin
          off_cnt <= off_cnt + 1'b1;
          if (off_cnt + 1'b1 == SAMPLE) begin
            sampling <= 1'b0;
            cyc_pulse <= 1'b1;
            vout_low <= !sense_over_half_ovp_i;
          end
        end
      end
    end
  end

  // Protection state: restart and latch
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_WAIT_UP;
      restarts_left <= 2'h1;
      overload_shutdown_o <= 1'b0;
      latched_off_o <= 1'b0;
      power_down_o <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (latch_req) begin
            state <= ST_LATCH;
            latched_off_o <= 1'b1;
            power_down_o <= 1'b1;
          end else if (demand_over_400mv_i && ovl_cnt >= ovl_limit) begin
            state <= ST_WAIT_LOW;
            overload_shutdown_o <= 1'b1;
            restarts_left <= `FPS_RESTARTS;
          end else if (supply_below_lockout_i) begin
            state <= ST_WAIT_LOW;
            restarts_left <= 2'h1;
          end
        end
        ST_WAIT_LOW: begin
          if (latch_req) begin
            state <= ST_LATCH;
            latched_off_o <= 1'b1;
            power_down_o <= 1'b1;
          end else if (supply_below_lockout_i) begin
            state <= ST_WAIT_UP;
            power_down_o <= 1'b1;
          end
        end
        ST_WAIT_UP: begin
          if (latch_req) begin
            state <= ST_LATCH;
            latched_off_o <= 1'b1;
            power_down_o <= 1'b1;
          end else if (supply_at_startup_i) begin
            power_down_o <= 1'b0;
            if (restarts_left <= 2'h1) begin
              state <= ST_RUN;
              overload_shutdown_o <= 1'b0;
            end else begin
              restarts_left <= restarts_left - 2'h1;
              state <= ST_WAIT_LOW;
            end
          end
        end
        ST_LATCH: begin
          // Only supply removal (reset) leaves this state
          latched_off_o <= 1'b1;
          power_down_o <= 1'b1;
        end
        default: state <= ST_LATCH;
      endcase
    end
  end
endmodule // fps_sequencer

// [bench/fps_sw_model.sv]
// Switch and sense network model for the sequencer bench.
// Assumes gate_i is the registered gate on clk_i.
`timescale 1ns/100ps
module fps_sw_model (
  input wire clk_i,
  input wire gate_i,
  input wire [9:0] ramp_i,
  input wire ovp_i,
  output wire cur_o,
  output wire ovp_o
);
  reg [9:0] n = 10'h000;
  always @(posedge clk_i)
    n <= gate_i ? n + 10'h001 : 10'h000;
  // Current ramps only while the switch conducts
  assign cur_o = gate_i && n >= ramp_i;
  // Output voltage shows only in the secondary stroke
  assign ovp_o = !gate_i && ovp_i;
endmodule // fps_sw_model

// [bench/fps_sequencer_asserts.sv]
// Port checks for the flyback sequencer.
// Assumes one clock and the async active-high reset.
`timescale 1ns/100ps
`include "fps_defs.vh"
module fps_sequencer_asserts (
  input wire clk_i,
  input wire sys_rst_i,
  input wire junction_hot_i,
  input wire [1:0] power_mode_i,
  input wire gate_o,
  input wire peak_low_clamp_o,
  input wire peak_boost_o,
  input wire opp_comp_en_o,
  input wire overload_shutdown_o,
  input wire latched_off_o,
  input wire power_down_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  reg [9:0] on_n;
  // Ten bits are enough: the on-time is capped well below 1024
  always @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i) on_n <= 10'h000;
    else on_n <= gate_o ? on_n + 10'h001 : 10'h000;
  sequence s_off;
    $fell(gate_o) && !power_down_o && !overload_shutdown_o;
  endsequence
  // Mode outputs lag the mode input by one register
  sequence s_run;
    !$past(sys_rst_i) && !power_down_o;
  endsequence
  blank_min_a: assert property (s_off |-> on_n >= 10'd37)
    else $error("on-time under blanking");
  max_on_a: assert property (s_off |-> on_n <= 10'd867)
    else $error("on-time over maximum");
  hot_latch_a: assert property (junction_hot_i |-> ##[1:3] latched_off_o)
    else $error("hot junction not latched");
  latch_down_a: assert property (latched_off_o |-> power_down_o && !gate_o)
    else $error("latched but not powered down");
  restart_off_a: assert property (overload_shutdown_o |-> !gate_o)
    else $error("gate during restart");
  low_clamp_a: assert property (s_run |->
    peak_low_clamp_o == ($past(power_mode_i) == `FPS_MODE_LOW))
    else $error("low clamp wrong");
  peak_boost_a: assert property (s_run |->
    peak_boost_o == ($past(power_mode_i) == `FPS_MODE_PEAK))
    else $error("peak boost wrong");
  opp_comp_a: assert property (s_run |->
    opp_comp_en_o == ($past(power_mode_i) < `FPS_MODE_MED))
    else $error("compensation enable wrong");
endmodule // fps_sequencer_asserts
bind fps_sequencer fps_sequencer_asserts u_fps_sequencer_asserts (
  .clk_i, .sys_rst_i, .junction_hot_i, .power_mode_i, .gate_o,
  .peak_low_clamp_o, .peak_boost_o, .opp_comp_en_o,
  .overload_shutdown_o, .latched_off_o, .power_down_o);

// [bench/tb.sv]
// Bench for the flyback sequencer with a switch model.
// Assumes fps_defs.vh on the include path.
`timescale 1ns/100ps
`include "fps_defs.vh"
module tb;
  localparam OVL = 18000;
  localparam [79:0] PER = {16'h04E2, 16'h2710, 16'h1388, 16'h0783, 16'h03C2};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg d4 = 1'b0, dm = 1'b1, hf = 1'b1, so = 1'b0, sb = 1'b0, sl = 1'b0;
  reg ss = 1'b1, hm = 1'b0, ht = 1'b0, sel = 1'b0, pg = 1'b0;
  reg [1:0] md = 2'h1;
  reg [9:0] rp = 10'h03C;
  reg [31:0] lf = 32'hEDB2;
  wire cur, sov, g, lat, ovl, grd;
  integer errors = 0, n_compared = 0, t, a, i, np, ts;
  fps_sequencer #(.OVL_CYC(OVL)) u_fps_sequencer (.clk_i(clk),
    .sys_rst_i(rst), .demand_over_400mv_i(d4), .demand_above_min_i(dm),
    .current_over_target_i(cur), .sense_over_ovp_i(sov),
    .sense_over_half_ovp_i(hf), .supply_over_ovp_i(so & ~sel),
    .supply_below_burst_i(sb), .supply_below_lockout_i(sl),
    .supply_at_startup_i(ss), .high_mains_i(hm), .junction_hot_i(ht),
    .power_mode_i(md), .gate_o(g), .peak_low_clamp_o(),
    .peak_boost_o(), .opp_comp_en_o(), .overload_shutdown_o(ovl),
    .latched_off_o(lat), .runaway_current_guard_o(grd), .power_down_o());
  fps_sw_model u_fps_sw_model (.clk_i(clk), .gate_i(g), .ramp_i(rp),
    .ovp_i(so & sel), .cur_o(cur), .ovp_o(sov));
  initial forever #4 clk = ~clk;
  // Whole run is near 95k cycles; the limit is 100k cycles
  initial begin
    #800000;
    errors = errors + 1;
    test_done;
  end
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [31:0] e, s, l, input [63:0] m);
    begin
      n_compared = n_compared + 1;
      if (^s === 1'bx || s + l < e || s > e + l) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s exp %0d got %0d", m, e, s);
      end
    end
  endtask
  task ew(input v);
    for (t = 0; g !== v && t < 40000; t = t + 1) @(negedge clk);
  endtask
  task cyc(input integer n);
    repeat (n) begin
      ew(1);
      ew(0);
      repeat (260) @(negedge clk);
    end
  endtask
  task cnt(input integer n);
    begin
      np = 0;
      repeat (n) begin
        @(negedge clk);
        if (g === 1'b1 && pg === 1'b0) np = np + 1;
        pg = g;
      end
    end
  endtask
  task rpulse;
    begin
      @(posedge clk) rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
    end
  endtask
  task test_done;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    rpulse;
    for (i = 0; i < 5; i = i + 1) begin
      lf = nx(lf);
      @(posedge clk);
      rp <= 10'd40 + {2'h0, lf[7:0]};
      md <= i[1:0];
      hm <= i == 4;
      ew(0);
      ew(1);
      ew(0);
      a = t;
      chk(rp + 2, a, 2, "on_time");
      ew(1);
      chk(PER[i*16 +: 16], a + t, 1, "period");
    end
    @(posedge clk);
    d4 <= 1'b1;
    hf <= 1'b0;
    rp <= 10'h000;
    ts = $time;
    while (grd !== 1'b1 && $time - ts < 16000) @(negedge clk);
    chk(1, grd, 0, "guard");
    ew(0);
    ew(1);
    ew(0);
    chk(37, t, 1, "blank");
    ew(1);
    ew(0);
    a = t;
    ew(1);
    chk(3500, a + t, 1, "stretch");
    while (ovl !== 1'b1 && $time - ts < 96000) @(negedge clk);
    chk(OVL / 2, ($time - ts) / 8, 3, "ovl_half");
    @(posedge clk);
    d4 <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      chk(1, ovl, 0, "ovl_hold");
      @(posedge clk);
      sl <= 1'b1;
      ss <= 1'b0;
      repeat (20) @(posedge clk);
      sl <= 1'b0;
      ss <= 1'b1;
      repeat (20) @(negedge clk);
    end
    ew(1);
    chk(1, g, 0, "resume");
    @(posedge clk);
    d4 <= 1'b1;
    hf <= 1'b1;
    ts = $time;
    while (ovl !== 1'b1 && $time - ts < 176000) @(negedge clk);
    chk(OVL, ($time - ts) / 8, 3, "ovl_full");
    chk(0, grd, 0, "no_guard");
    for (i = 0; i < 2; i = i + 1) begin
      rpulse;
      sel <= i[0];
      hm <= 1'b0;
      d4 <= 1'b0;
      so <= 1'b1;
      cyc(3);
      @(posedge clk);
      so <= 1'b0;
      cyc(1);
      @(posedge clk);
      so <= 1'b1;
      cyc(3);
      chk(0, lat, 0, "ovp3");
      cyc(1);
      chk(1, lat, 0, "ovp4");
      @(posedge clk);
      so <= 1'b0;
    end
    rpulse;
    dm <= 1'b0;
    md <= 2'h1;
    cnt(2000);
    chk(0, np, 0, "idle");
    @(posedge clk);
    sb <= 1'b1;
    cnt(4000);
    chk(2, np, 0, "burst");
    @(posedge clk);
    ht <= 1'b1;
    cnt(8);
    chk(1, lat, 0, "hot");
    test_done;
  end
endmodule // tb
